// [verilog/csm_pkg.sv]
// csm_pkg: constants, register map and types for the clock status pin mapper
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package csm_pkg;

	// ------------------------------------------------------------------------
	// register port geometry
	// ------------------------------------------------------------------------
	localparam int unsigned CSM_ADDR_W = 5; // register number width
	localparam int unsigned CSM_DATA_W = 16; // register width

	// ------------------------------------------------------------------------
	// register numbers
	// ------------------------------------------------------------------------
	localparam logic [4:0] CSM_REG_CFG3 = 5'h03; // event mapping register
	localparam logic [4:0] CSM_REG_CFG4 = 5'h04; // input enable register
	localparam logic [4:0] CSM_REG_STAT21 = 5'h15; // live status register

	// ------------------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------------------
	localparam logic [15:0] CSM_CFG3_RST = 16'h0000; // no events mapped
	localparam logic [15:0] CSM_CFG4_RST = 16'h0000; // secondary input off
	localparam logic [15:0] CSM_RD_IDLE = 16'h0000; // read bus when idle
	localparam logic CSM_LOSS_RST = 1'h1; // loss flag until proven present

	// ------------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------------
	localparam int unsigned CSM_FIELD_W = 3; // enable bits per pin
	localparam int unsigned CSM_PIN_B_LSB = 7; // pin b field, bits 9..7
	localparam int unsigned CSM_PIN_A_LSB = 10; // pin a field, bits 12..10
	localparam int unsigned CSM_EV_SEL = 2; // field bit: reference choice
	localparam int unsigned CSM_EV_LOSS = 1; // field bit: reference loss
	localparam int unsigned CSM_EV_UNLOCK = 0; // field bit: loop unlock
	localparam int unsigned CSM_CFG4_SEC_EN = 5; // secondary input enable
	localparam int unsigned CSM_STAT_SEL = 0; // status: reference choice
	localparam int unsigned CSM_STAT_LOSS = 1; // status: reference loss
	localparam int unsigned CSM_STAT_UNLOCK = 2; // status: loop unlock

	// ------------------------------------------------------------------------
	// lock detector counts
	// ------------------------------------------------------------------------
	localparam int unsigned CSM_LD_WINDOW_CYCLES = 1024; // observation window
	localparam int unsigned CSM_LD_SLIP_LIMIT = 4; // slips tolerated per window

	// lock detector state
	typedef enum logic [0:0] {
		CSM_LD_LOCKED = 1'b0,
		CSM_LD_UNLOCKED = 1'b1
	} csm_lock_state_t;

endpackage : csm_pkg

// [verilog/csm_lock_detector.sv]
// csm_lock_detector: digital cycle-slip lock detector for the loop
`timescale 1ns/10ps
module csm_lock_detector
	import csm_pkg::*;
#(
	parameter int unsigned WINDOW_CYCLES = CSM_LD_WINDOW_CYCLES,
	parameter int unsigned SLIP_LIMIT = CSM_LD_SLIP_LIMIT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic slip,
	output logic unlock
);

	// ------------------------------------------------------------------------
	// counters and state
	// ------------------------------------------------------------------------
	localparam int unsigned WIN_W = $clog2(WINDOW_CYCLES + 1);
	localparam int unsigned SLP_W = $clog2(SLIP_LIMIT + 2);

	logic [WIN_W-1:0] win_cnt; // cycles into current window
	logic [SLP_W-1:0] slip_cnt; // slips seen in current window
	csm_lock_state_t state; // locked or unlocked
	logic win_end; // last cycle of a window
	logic over; // this slip exceeds the tolerated count

	assign win_end = (win_cnt == WIN_W'(WINDOW_CYCLES - 1));
	assign over = slip && (slip_cnt == SLP_W'(SLIP_LIMIT));

	// window counter restarts on overflow of slips or at window end
	always_ff @(posedge clk) begin
		if (rst || over || win_end) begin
			win_cnt <= '0;
		end else begin
			win_cnt <= WIN_W'(win_cnt + 1'b1);
		end
	end

	// slip counter, reset together with the window
	always_ff @(posedge clk) begin
		if (rst || over || win_end) begin
			slip_cnt <= '0;
		end else if (slip) begin
			slip_cnt <= SLP_W'(slip_cnt + 1'b1);
		end
	end

	// too many slips unlock; a whole window without slips relocks
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= CSM_LD_UNLOCKED;
		end else begin
			unique case (state)
				CSM_LD_LOCKED: begin
					if (over) begin
						state <= CSM_LD_UNLOCKED;
					end
				end
				CSM_LD_UNLOCKED: begin
					if (win_end && !slip && (slip_cnt == '0)) begin
						state <= CSM_LD_LOCKED;
					end
				end
			endcase
		end
	end

	assign unlock = (state == CSM_LD_UNLOCKED);

	// excess slips must show as unlock on the next cycle
	a_slip_unlocks: assert property (@(posedge clk) disable iff (rst)
		over |=> unlock)
		else $error("excess slips did not unlock");

	// relock only after a clean window end
	a_relock_clean: assert property (@(posedge clk) disable iff (rst)
		$fell(unlock) |-> $past(win_end) && ($past(slip_cnt) == '0))
		else $error("relock without a clean window");

endmodule : csm_lock_detector

// [verilog/csm_status_mapper.sv]
// csm_status_mapper: routes synthesizer vitals to two status pins and registers
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps
module csm_status_mapper
	import csm_pkg::*;
#(
	parameter int unsigned WINDOW_CYCLES = CSM_LD_WINDOW_CYCLES,
	parameter int unsigned SLIP_LIMIT = CSM_LD_SLIP_LIMIT
) (
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [CSM_ADDR_W-1:0] reg_addr,
	input wire logic [CSM_DATA_W-1:0] reg_wr_data,
	input wire logic reg_wr_stb,
	input wire logic reg_rd_stb,
	output logic [CSM_DATA_W-1:0] reg_rd_data,
	// raw vitals from the clock path, asynchronous to clk
	input wire logic ref_select_in,
	input wire logic ref_loss_in,
	input wire logic phase_slip_in,
	// outputs
	output logic secondary_ref_input_en,
	output logic status_out_a,
	output logic status_out_b
);

	// ------------------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------------------
	localparam int unsigned NUM_RAW = 3; // vitals crossing into clk
	localparam int unsigned RAW_SEL = 0; // raw index: reference choice
	localparam int unsigned RAW_LOSS = 1; // raw index: reference loss
	localparam int unsigned RAW_SLIP = 2; // raw index: phase slip

	logic [NUM_RAW-1:0] raw_in; // gathered raw vitals
	logic [NUM_RAW-1:0] sync_meta; // first stage, read only by second
	logic [NUM_RAW-1:0] sync_out; // second stage, safe to use

	assign raw_in = {phase_slip_in, ref_loss_in, ref_select_in};

	// two flops per vital; nothing but the second flop looks at the first
	generate
		for (genvar g = 0; g < NUM_RAW; g++) begin : g_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					sync_meta[g] <= 1'b0;
					sync_out[g] <= 1'b0;
				end else begin
					sync_meta[g] <= raw_in[g];
					sync_out[g] <= sync_meta[g];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------------------
	logic [CSM_DATA_W-1:0] cfg3; // event mapping, bits 12..7 used
	logic [CSM_DATA_W-1:0] cfg4; // input enables, bit 5 used
	logic wr_cfg3; // write hits register 3
	logic wr_cfg4; // write hits register 4

	assign wr_cfg3 = reg_wr_stb && (reg_addr == CSM_REG_CFG3);
	assign wr_cfg4 = reg_wr_stb && (reg_addr == CSM_REG_CFG4);

	// register 3 holds the per-pin event enables
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg3 <= CSM_CFG3_RST;
		end else if (wr_cfg3) begin
			cfg3 <= reg_wr_data;
		end
	end

	// register 4 holds the secondary input enable
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg4 <= CSM_CFG4_RST;
		end else if (wr_cfg4) begin
			cfg4 <= reg_wr_data;
		end
	end

	// secondary input enable drives the input stage outside this block
	assign secondary_ref_input_en = cfg4[CSM_CFG4_SEC_EN];

	// ------------------------------------------------------------------------
	// lock detector
	// ------------------------------------------------------------------------
	logic unlock_flag; // loop unlock, high while not locked

	// slips feed the digital detector that produces the unlock event
	csm_lock_detector #(
		.WINDOW_CYCLES(WINDOW_CYCLES),
		.SLIP_LIMIT(SLIP_LIMIT)
	) u_lock_det (
		.clk(clk),
		.rst(rst),
		.slip(sync_out[RAW_SLIP]),
		.unlock(unlock_flag)
	);

	// ------------------------------------------------------------------------
	// event flags
	// ------------------------------------------------------------------------
	logic sel_flag; // 0 primary drives loop, 1 secondary
	logic loss_flag; // 0 reference present, 1 lost
	logic next_loss; // loss flag value for the next cycle

	// reference choice follows the mux state directly
	always_ff @(posedge clk) begin
		if (rst) begin
			sel_flag <= 1'b0;
		end else begin
			sel_flag <= sync_out[RAW_SEL];
		end
	end

	// loss only means something with the secondary input enabled;
	// software must set the enable for the loss flag to be used
	always_comb begin
		if (cfg4[CSM_CFG4_SEC_EN]) begin
			next_loss = sync_out[RAW_LOSS];
		end else begin
			next_loss = 1'b1;
		end
	end

	// loss flag register
	always_ff @(posedge clk) begin
		if (rst) begin
			loss_flag <= CSM_LOSS_RST;
		end else begin
			loss_flag <= next_loss;
		end
	end

	// ------------------------------------------------------------------------
	// pin mapping
	// ------------------------------------------------------------------------
	logic [CSM_FIELD_W-1:0] ev_terms; // pin-level terms of the three events
	logic [1:0] next_pin; // next pin levels, index 0 pin b, 1 pin a
	logic [1:0] pin_q; // registered pin levels

	// pin level of unlock is inverted: high while locked
	always_comb begin
		ev_terms = '0;
		ev_terms[CSM_EV_SEL] = sel_flag;
		ev_terms[CSM_EV_LOSS] = loss_flag;
		ev_terms[CSM_EV_UNLOCK] = ~unlock_flag;
	end

	// each pin ORs the events that its three-bit field enables
	generate
		for (genvar p = 0; p < 2; p++) begin : g_pin
			localparam int unsigned LSB = CSM_PIN_B_LSB + p * CSM_FIELD_W;
			assign next_pin[p] = |(cfg3[LSB +: CSM_FIELD_W] & ev_terms);
		end
	endgenerate

	// pins come from flops so they never glitch on a mapping change
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_q <= 2'h0;
		end else begin
			pin_q <= next_pin;
		end
	end

	assign status_out_b = pin_q[0];
	assign status_out_a = pin_q[1];

	// ------------------------------------------------------------------------
	// register read path
	// ------------------------------------------------------------------------
	logic [CSM_DATA_W-1:0] stat_word; // live status, read-only
	logic [CSM_DATA_W-1:0] next_rd; // read data for the next cycle

	// status word reflects the live flags; unused bits read zero
	always_comb begin
		stat_word = '0;
		stat_word[CSM_STAT_SEL] = sel_flag;
		stat_word[CSM_STAT_LOSS] = loss_flag;
		stat_word[CSM_STAT_UNLOCK] = unlock_flag;
	end

	// address decode; unmapped numbers read as zero
	always_comb begin
		next_rd = CSM_RD_IDLE;
		if (reg_rd_stb) begin
			unique case (reg_addr)
				CSM_REG_CFG3: next_rd = cfg3;
				CSM_REG_CFG4: next_rd = cfg4;
				CSM_REG_STAT21: next_rd = stat_word;
				default: next_rd = CSM_RD_IDLE;
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rd_data <= CSM_RD_IDLE;
		end else begin
			reg_rd_data <= next_rd;
		end
	end

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// secondary disabled: loss flag high two cycles later whatever the input
	a_loss_forced: assert property (
		!cfg4[CSM_CFG4_SEC_EN] [*2] |=> loss_flag)
		else $error("loss flag not forced high");

	// secondary enabled: loss flag follows the raw input three edges late
	a_loss_tracks: assert property (
		cfg4[CSM_CFG4_SEC_EN] [*4] |-> loss_flag == $past(ref_loss_in, 3))
		else $error("loss flag does not follow input");

	// reference choice follows its input three edges late
	a_sel_tracks: assert property (
		##3 1'b1 |-> sel_flag == $past(ref_select_in, 3))
		else $error("reference choice flag wrong");

	// field of all zeros keeps pin a low
	a_pin_a_idle: assert property (
		cfg3[CSM_PIN_A_LSB +: CSM_FIELD_W] == 3'h0 |=> !status_out_a)
		else $error("pin a high with no event mapped");

	// pin b with only the choice bit shows the choice flag
	a_pin_b_sel: assert property (
		cfg3[CSM_PIN_B_LSB +: CSM_FIELD_W] == 3'h4 |=> status_out_b == $past(sel_flag))
		else $error("pin b does not show reference choice");

	// pin a with loss and unlock enabled is their OR at pin polarity
	a_pin_or: assert property (
		cfg3[CSM_PIN_A_LSB +: CSM_FIELD_W] == 3'h3
		|=> status_out_a == ($past(loss_flag) | !$past(unlock_flag)))
		else $error("pin a is not the OR of its events");

	// pin b with only unlock shows the inverse of the status bit
	a_unlock_inverse: assert property (
		reg_rd_stb && reg_addr == CSM_REG_STAT21
		&& cfg3[CSM_PIN_B_LSB +: CSM_FIELD_W] == 3'h1
		|=> status_out_b != reg_rd_data[CSM_STAT_UNLOCK])
		else $error("unlock bit and pin share polarity");

	// status read returns the live loss and choice flags
	a_status_read: assert property (
		reg_rd_stb && reg_addr == CSM_REG_STAT21
		|=> reg_rd_data[CSM_STAT_LOSS] == $past(loss_flag)
		&& reg_rd_data[CSM_STAT_SEL] == $past(sel_flag))
		else $error("status read does not show live flags");

	// writes to the status register change no configuration
	a_status_ro: assert property (
		reg_wr_stb && reg_addr == CSM_REG_STAT21 |=> $stable(cfg3) && $stable(cfg4))
		else $error("status write changed configuration");

	// read data is zero outside the cycle after a read strobe
	a_rd_idle: assert property (
		!reg_rd_stb |=> reg_rd_data == CSM_RD_IDLE)
		else $error("read data stands too long");

	// a write to register 3 lands whole on the next edge
	a_cfg3_write: assert property (
		wr_cfg3 |=> cfg3 == $past(reg_wr_data))
		else $error("register 3 write lost");

	// secondary enable output follows the written bit
	a_sec_en_write: assert property (
		wr_cfg4 |=> secondary_ref_input_en == $past(reg_wr_data[CSM_CFG4_SEC_EN]))
		else $error("secondary enable does not follow write");

	// field of all zeros keeps pin b low
	a_pin_b_idle: assert property (
		cfg3[CSM_PIN_B_LSB +: CSM_FIELD_W] == 3'h0 |=> !status_out_b)
		else $error("pin b high with no event mapped");

	// pin a with only the loss bit shows the loss flag
	a_pin_a_loss: assert property (
		cfg3[CSM_PIN_A_LSB +: CSM_FIELD_W] == 3'h2 |=> status_out_a == $past(loss_flag))
		else $error("pin a does not show reference loss");

	// pin a with only unlock is high while locked
	a_pin_a_unlock: assert property (
		cfg3[CSM_PIN_A_LSB +: CSM_FIELD_W] == 3'h1 |=> status_out_a == !$past(unlock_flag))
		else $error("pin a unlock polarity wrong");

	// pin b with all three enabled is the OR of every event
	a_pin_b_all: assert property (
		cfg3[CSM_PIN_B_LSB +: CSM_FIELD_W] == 3'h7
		|=> status_out_b == ($past(sel_flag) | $past(loss_flag) | !$past(unlock_flag)))
		else $error("pin b is not the OR of all events");

	// status read keeps its unused upper bits at zero
	a_stat_upper: assert property (
		reg_rd_stb && reg_addr == CSM_REG_STAT21
		|=> reg_rd_data[CSM_DATA_W-1:CSM_STAT_UNLOCK+1] == '0)
		else $error("status read shows unused bits");

	// unmapped register numbers read as zero
	a_unmapped_rd: assert property (
		reg_rd_stb && reg_addr != CSM_REG_CFG3 && reg_addr != CSM_REG_CFG4
		&& reg_addr != CSM_REG_STAT21 |=> reg_rd_data == CSM_RD_IDLE)
		else $error("unmapped read not zero");

endmodule : csm_status_mapper

// [test/csm_vitals_model.sv]
// csm_vitals_model: clock-path model driving raw vitals into the status mapper
`timescale 1ns/10ps
module csm_vitals_model (
	input wire logic clk,
	output logic ref_select_in,
	output logic ref_loss_in,
	output logic phase_slip_in
);
	// ------------------------------------------------------------------------
	// raw vitals: idle levels, then changed just after rising edges
	// ------------------------------------------------------------------------
	initial begin
		ref_select_in = 1'b0; // primary feeds the loop
		ref_loss_in = 1'b0; // reference present
		phase_slip_in = 1'b0; // no slips
	end

	// new reference choice and loss level, applied at the next rising edge
	task automatic set_vitals(input logic sel, input logic loss);
		@(posedge clk);
		ref_select_in <= sel;
		ref_loss_in <= loss;
	endtask : set_vitals

	// slip line held high for n whole clock cycles
	task automatic slip_burst(input int n);
		@(posedge clk);
		phase_slip_in <= 1'b1;
		repeat (n) @(posedge clk);
		phase_slip_in <= 1'b0;
	endtask : slip_burst
endmodule : csm_vitals_model

// [test/csm_status_mapper_tb_top.sv]
// csm_status_mapper_tb_top: register and pin tests of the status mapper
`timescale 1ns/10ps
module csm_status_mapper_tb_top;
	import csm_pkg::*;
	localparam int unsigned WIN = 16; // shortened lock window
	localparam int unsigned SLIPS = 2; // shortened slip limit
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [CSM_ADDR_W-1:0] reg_addr = '0;
	logic [CSM_DATA_W-1:0] reg_wr_data = '0;
	logic reg_wr_stb = 1'b0;
	logic reg_rd_stb = 1'b0;
	logic [CSM_DATA_W-1:0] reg_rd_data;
	logic ref_select_in, ref_loss_in, phase_slip_in;
	logic secondary_ref_input_en, status_out_a, status_out_b;
	logic [15:0] rd_val; // last read word
	int bad_count = 0;
	int check_count = 0;

	// ------------------------------------------------------------------------
	// clock, design and vitals model
	// ------------------------------------------------------------------------
	always #20 clk = ~clk;

	csm_status_mapper #(.WINDOW_CYCLES(WIN), .SLIP_LIMIT(SLIPS)) uut (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data),
		.ref_select_in(ref_select_in), .ref_loss_in(ref_loss_in),
		.phase_slip_in(phase_slip_in), .secondary_ref_input_en(secondary_ref_input_en),
		.status_out_a(status_out_a), .status_out_b(status_out_b));

	csm_vitals_model pm (.clk(clk), .ref_select_in(ref_select_in),
		.ref_loss_in(ref_loss_in), .phase_slip_in(phase_slip_in));

	// ------------------------------------------------------------------------
	// bus tasks and comparison
	// ------------------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one-cycle write strobe
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_stb <= 1'b1;
		@(posedge clk);
		reg_wr_stb <= 1'b0;
	endtask : wr

	// one-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd_stb <= 1'b1;
		@(posedge clk);
		reg_rd_stb <= 1'b0;
		#1;
		d = reg_rd_data;
	endtask : rd

	// wait n edges, then settle
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	// expected pin level for one three-bit field
	function automatic logic pin_exp(input logic [2:0] f, input logic s, input logic l,
		input logic u);
		return (f[2] & s) | (f[1] & l) | (f[0] & ~u);
	endfunction : pin_exp

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results

	// ------------------------------------------------------------------------
	// watchdog, well beyond the roughly fifteen hundred cycles the tests take
	// ------------------------------------------------------------------------
	initial begin
		#(40 * 20000);
		bad_count++;
		results();
	end

	// ------------------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		cyc(3);
		// reset values: nothing mapped, loss forced, detector unlocked
		rd(CSM_REG_CFG3, rd_val); check("cfg3", rd_val, 16'h0000);
		rd(CSM_REG_CFG4, rd_val); check("cfg4", rd_val, 16'h0000);
		rd(CSM_REG_STAT21, rd_val); check("stat", rd_val, 16'h0006);
		check("pins", {14'h0000, status_out_a, status_out_b}, 16'h0000);
		check("sec_en", {15'h0000, secondary_ref_input_en}, 16'h0000);
		$display("test reset done");

		// stored words, read-only status, unmapped place
		wr(CSM_REG_CFG3, 16'ha5c3);
		rd(CSM_REG_CFG3, rd_val); check("cfg3", rd_val, 16'ha5c3);
		wr(CSM_REG_CFG4, 16'h0020);
		rd(CSM_REG_CFG4, rd_val); check("cfg4", rd_val, 16'h0020);
		check("sec_en", {15'h0000, secondary_ref_input_en}, 16'h0001);
		// detector has locked after its first clean window by now
		wr(CSM_REG_STAT21, 16'hffff);
		rd(CSM_REG_STAT21, rd_val); check("stat", rd_val, 16'h0000);
		rd(5'h1f, rd_val); check("unmapped", rd_val, 16'h0000);
		cyc(1); check("rd idle", reg_rd_data, 16'h0000);
		$display("test registers done");

		// loss flag held high while the secondary input is off
		pm.set_vitals(1'b0, 1'b0);
		wr(CSM_REG_CFG4, 16'h0000); cyc(6);
		rd(CSM_REG_STAT21, rd_val); check("loss off", rd_val, 16'h0002);
		wr(CSM_REG_CFG4, 16'h0020); cyc(6);
		rd(CSM_REG_STAT21, rd_val); check("loss ok", rd_val, 16'h0000);
		pm.set_vitals(1'b0, 1'b1); cyc(6);
		rd(CSM_REG_STAT21, rd_val); check("loss set", rd_val, 16'h0002);
		pm.set_vitals(1'b0, 1'b0);
		$display("test loss done");

		// lock detector: locks after quiet windows, limit slips tolerated
		// the shortened wait keeps both tolerated slips inside one window
		wr(CSM_REG_CFG3, 16'h0480); cyc(3 * WIN - 4);
		rd(CSM_REG_STAT21, rd_val); check("locked", rd_val, 16'h0000);
		check("pins lk", {14'h0000, status_out_a, status_out_b}, 16'h0003);
		pm.slip_burst(SLIPS); cyc(6);
		rd(CSM_REG_STAT21, rd_val); check("slip lim", rd_val, 16'h0000);
		cyc(WIN);
		pm.slip_burst(SLIPS + 1); cyc(6);
		rd(CSM_REG_STAT21, rd_val); check("unlock", rd_val, 16'h0004);
		check("pins ul", {14'h0000, status_out_a, status_out_b}, 16'h0000);
		cyc(3 * WIN);
		rd(CSM_REG_STAT21, rd_val); check("relock", rd_val, 16'h0000);
		$display("test lock done");

		// every mapping value against every reference and loss level, locked
		for (int v = 0; v < 4; v++) begin
			pm.set_vitals(v[1], v[0]); cyc(6);
			rd(CSM_REG_STAT21, rd_val);
			check("stat map", rd_val, {14'h0000, v[0], v[1]});
			for (int f = 0; f < 64; f++) begin
				wr(CSM_REG_CFG3, {3'h0, f[5:0], 7'h00}); cyc(3);
				check("pin a", {15'h0000, status_out_a},
					{15'h0000, pin_exp(f[5:3], v[1], v[0], 1'b0)});
				check("pin b", {15'h0000, status_out_b},
					{15'h0000, pin_exp(f[2:0], v[1], v[0], 1'b0)});
			end
		end
		$display("test mapping done");
		results();
	end
endmodule : csm_status_mapper_tb_top
